// ### common/mrd_pkg.sv
// Constants and types shared by the memory remap and abort decoder.
package mrd_pkg;

   // Address map boundaries.
   localparam logic [31:0] WIN_MASK = 32'h0000_003f;
   localparam logic [31:0] RSV0_LAST = 32'h3fff_ffff;
   localparam logic [31:0] SRAM_BASE = 32'h4000_0000;
   localparam logic [31:0] BOOT_BASE = 32'h7fff_e000;
   localparam logic [31:0] EXT_BASE = 32'h8000_0000;
   localparam logic [31:0] EXT_LAST = 32'h83ff_ffff;
   localparam logic [31:0] APB_BASE = 32'he000_0000;
   localparam logic [31:0] APB_LAST = 32'he01f_ffff;
   localparam logic [31:0] AHB_BASE = 32'hffe0_0000;
   localparam int SLOT_LSB = 14;
   localparam int SLOT_W = 7;
   localparam int BANK_LSB = 24;

   // Register byte offsets on the configuration bus.
   localparam logic [4:0] OFF_BANK0 = 5'h00;
   localparam logic [4:0] OFF_BANK3 = 5'h0c;
   localparam logic [4:0] OFF_MAP = 5'h10;
   localparam logic [4:0] OFF_STAT = 5'h14;

   // Bank configuration fields.
   localparam int F_IDCY = 0;
   localparam int F_WST1 = 5;
   localparam int F_RBLE = 10;
   localparam int F_WST2 = 11;
   localparam int F_PVIOL = 25;
   localparam int F_WP = 26;
   localparam int F_BM = 27;
   localparam int F_MW = 28;
   localparam logic [31:0] BCFG_WMASK = 32'h3c00_ffef;
   localparam logic [31:0] BCFG_RST0 = 32'h0000_fbef;
   localparam logic [31:0] BCFG_RST1 = 32'h2000_fbef;
   localparam logic [31:0] BCFG_RST2 = 32'h1000_fbef;
   localparam logic [31:0] BCFG_RST3 = 32'h0000_fbef;

   // Mapping mode codes and bank widths.
   localparam logic [1:0] MODE_BOOT = 2'h0;
   localparam logic [1:0] MODE_RAM = 2'h1;
   localparam logic [1:0] MODE_EXT = 2'h2;
   localparam logic [1:0] MW_8 = 2'h0;
   localparam logic [1:0] MW_16 = 2'h1;

   // Access sizes.
   localparam logic [1:0] SZ_BYTE = 2'h0;
   localparam logic [1:0] SZ_HALF = 2'h1;

   typedef enum logic [2:0] {
      RGN_NONE, RGN_BOOT, RGN_SRAM, RGN_EXT, RGN_APB, RGN_AHB
   } mrd_region_t;

   typedef enum {
      ST_IDLE, ST_DECODE, ST_TURN, ST_LAUNCH, ST_STROBE, ST_HOLD, ST_DONE
   } mrd_state_t;

endpackage

// ### hdl/mrd_decoder.sv
// Memory remap, abort decoder and external bank controller.
// Operation
// - Lowest 64 bytes are remapped to the source of the active mode.
// - Any reset selects boot loader mapping.
// - User RAM mode serves the low window from SRAM start.
// - User external mode serves the low window from external memory start.
// - Remapped regions stay reachable at their native addresses.
// - Boot block sits at top of on-chip space; other memory is fixed.
// - Addresses above the window up to the first gigabyte abort.
// - The gap between SRAM end and boot block aborts.
// - Range above external banks below peripherals aborts.
// - Reserved and unassigned peripheral slots abort.
// - Data accesses raise data abort, fetches raise prefetch abort.
// - Any fetch from either peripheral area raises prefetch abort.
// - Undefined offsets inside an assigned slot do not abort.
// - External controller serves four banks of up to 16 MB.
// - Bank chosen by address bits 25:24; 24 address bits driven out.
// - Banks occupy consecutive 16 MB ranges from the external base.
// - Each bank is 8, 16 or 32 bits wide.
// - Programmable turnaround idle cycles between accesses.
// - Programmable read and write wait states; burst reads use the write wait states.
// - Write protect, burst mode and read lane control per bank.
// - Bank zero boot width taken from boot select pins at reset.
// - Active-low chip selects, output enable, write enable, lane selects.
// - Write to protected bank sets sticky flag, cleared by writing one.
module mrd_decoder
   import mrd_pkg::*;
#(
   parameter int unsigned SRAM_BYTES = 16384,
   parameter logic [127:0] APB_SLOTS = 128'h8000_0000_0000_0000_0000_0000_0080_3fbf,
   parameter logic [127:0] AHB_SLOTS = 128'h8000_0000_0000_0000_0000_0000_0000_0001
) (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic cpu_req,
   input wire logic [31:0] cpu_addr,
   input wire logic cpu_fetch,
   input wire logic cpu_write,
   input wire logic [1:0] cpu_size,
   input wire logic [31:0] cpu_wdata,
   output logic cpu_ack,
   output logic [31:0] cpu_rdata,
   output mrd_pkg::mrd_region_t rsp_region,
   output logic [31:0] rsp_addr,
   output logic data_abort,
   output logic prefetch_abort,
   input wire logic boot_strap_pin,
   input wire logic [1:0] boot_select_pins,
   output logic [23:0] ext_addr,
   output logic [3:0] ext_cs_n,
   output logic ext_oe_n,
   output logic ext_we_n,
   output logic [3:0] lane_selects_n,
   output logic [31:0] ext_data_o,
   output logic ext_data_oe,
   input wire logic [31:0] ext_data_i
);
   import mrd_pkg::*;

   localparam logic [31:0] SRAM_END = SRAM_BASE + 32'(SRAM_BYTES);

   logic [31:0] bcfg_q [4];
   logic [3:0] protect_violation_flag_q;
   logic [1:0] mode_q;
   logic wait_q;
   logic [31:0] rdata_q;
   logic [2:0] strap_s1, strap_s2, strap_s3;
   logic [2:0] strap_stable_q;
   logic [2:0] strap_cap_q;
   logic capture_q;
   mrd_state_t st_q;
   logic [31:0] addr_q;
   logic fetch_q, write_q;
   logic [1:0] size_q;
   logic [31:0] wdata_q;
   logic [5:0] cnt_q;
   logic burst_q;
   logic wp_hit_q;
   logic [1:0] wp_bank_q;
   logic last_valid_q, last_write_q;
   logic [1:0] last_bank_q;
   logic [31:0] last_addr_q;
   logic ack_q, dab_q, pab_q;
   logic [31:0] crdata_q, raddr_q;
   mrd_region_t rgn_q;
   logic [23:0] eaddr_q;
   logic [3:0] cs_n_q, lanes_n_q;
   logic oe_n_q, we_n_q, doe_q;
   logic [31:0] dout_q;

   mrd_region_t dec_region;
   logic [31:0] dec_addr;
   logic dec_abort;
   logic [1:0] bank;
   logic [31:0] cfg;
   logic [3:0] lane_mask;
   logic [1:0] shift;
   logic need_turn, is_burst;

   // Remap window decode and abort map.
   always_comb begin
      dec_region = RGN_NONE;
      dec_addr = addr_q;
      if ((addr_q & ~WIN_MASK) == 32'h0000_0000) begin
         case (mode_q)
            MODE_RAM: begin
               dec_region = RGN_SRAM;
               dec_addr = SRAM_BASE | (addr_q & WIN_MASK);
            end
            MODE_EXT: begin
               dec_region = RGN_EXT;
               dec_addr = EXT_BASE | (addr_q & WIN_MASK);
            end
            default: begin
               dec_region = RGN_BOOT;
               dec_addr = BOOT_BASE | (addr_q & WIN_MASK);
            end
         endcase
      end else if (addr_q <= RSV0_LAST) begin
         dec_region = RGN_NONE;
      end else if (addr_q < SRAM_END) begin
         dec_region = RGN_SRAM;
      end else if (addr_q < BOOT_BASE) begin
         dec_region = RGN_NONE;
      end else if (addr_q < EXT_BASE) begin
         dec_region = RGN_BOOT;
      end else if (addr_q <= EXT_LAST) begin
         dec_region = RGN_EXT;
      end else if (addr_q < APB_BASE) begin
         dec_region = RGN_NONE;
      end else if (addr_q <= APB_LAST) begin
         if (APB_SLOTS[addr_q[SLOT_LSB +: SLOT_W]]) begin
            dec_region = RGN_APB;
         end
      end else if (addr_q >= AHB_BASE) begin
         if (AHB_SLOTS[addr_q[SLOT_LSB +: SLOT_W]]) begin
            dec_region = RGN_AHB;
         end
      end
      dec_abort = (dec_region == RGN_NONE) ||
                  (fetch_q && (dec_region == RGN_APB || dec_region == RGN_AHB));
   end

   // External access helpers for the current bank.
   always_comb begin
      bank = dec_addr[BANK_LSB +: 2];
      cfg = bcfg_q[bank];
      case (size_q)
         SZ_BYTE: lane_mask = 4'h1 << addr_q[1:0];
         SZ_HALF: lane_mask = addr_q[1] ? 4'hc : 4'h3;
         default: lane_mask = 4'hf;
      endcase
      case (cfg[F_MW +: 2])
         MW_8: shift = 2'h0;
         MW_16: shift = 2'h1;
         default: shift = 2'h2;
      endcase
      // Turnaround on bank or direction change.
      need_turn = last_valid_q && (bank != last_bank_q || write_q != last_write_q);
      is_burst = cfg[F_BM] && !write_q && last_valid_q && !last_write_q &&
                 bank == last_bank_q && dec_addr[31:4] == last_addr_q[31:4] &&
                 dec_addr[3:2] == last_addr_q[3:2] + 2'h1;
   end

   // Strap pins pass three flops; a value counts once stages two and three agree.
   always_ff @(posedge sys_clk) begin
      strap_s1 <= {boot_strap_pin, boot_select_pins};
      strap_s2 <= strap_s1;
      strap_s3 <= strap_s2;
      if (strap_s2 == strap_s3) begin
         strap_stable_q <= strap_s3;
      end
   end

   // Straps are caught on the first edge after reset release, never under reset.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         capture_q <= 1'b1;
         strap_cap_q <= 3'h0;
      end else if (capture_q) begin
         capture_q <= 1'b0;
         strap_cap_q <= strap_stable_q;
      end
   end

   // Bus slave answers one cycle after a request; waitrequest idles high.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         wait_q <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end else begin
         wait_q <= !((avs_read || avs_write) && wait_q);
         if (avs_read && wait_q) begin
            rdata_q <= 32'h0000_0000;
            if (avs_address <= OFF_BANK3) begin
               rdata_q <= (bcfg_q[avs_address[3:2]] & BCFG_WMASK) |
                          (32'(protect_violation_flag_q[avs_address[3:2]]) << F_PVIOL);
            end else if (avs_address[4:2] == OFF_MAP[4:2]) begin
               rdata_q <= 32'(mode_q);
            end else if (avs_address[4:2] == OFF_STAT[4:2]) begin
               rdata_q <= 32'(strap_cap_q);
            end
         end
      end
   end

   // Bank configuration and mapping mode registers.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         bcfg_q[0] <= BCFG_RST0;
         bcfg_q[1] <= BCFG_RST1;
         bcfg_q[2] <= BCFG_RST2;
         bcfg_q[3] <= BCFG_RST3;
         mode_q <= MODE_BOOT;
      end else begin
         // Bank zero width from boot pins.
         if (capture_q) begin
            bcfg_q[0][F_MW +: 2] <= strap_stable_q[1:0];
         end
         if (avs_write && !wait_q) begin
            if (avs_address <= OFF_BANK3) begin
               for (int b = 0; b < 4; b++) begin
                  if (avs_byteenable[b]) begin
                     bcfg_q[avs_address[3:2]][b*8 +: 8] <=
                        avs_writedata[b*8 +: 8] & BCFG_WMASK[b*8 +: 8];
                  end
               end
            end else if (avs_address[4:2] == OFF_MAP[4:2] && avs_byteenable[0] &&
                         avs_writedata[1:0] != 2'h3) begin
               mode_q <= avs_writedata[1:0];
            end
         end
      end
   end

   // Protect violation flags; a new violation wins over a clear in the same cycle.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         protect_violation_flag_q <= 4'h0;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (wp_hit_q && wp_bank_q == 2'(i)) begin
               protect_violation_flag_q[i] <= 1'b1;
            end else if (avs_write && !wait_q && avs_address[4:2] == 3'(i) &&
                         avs_byteenable[3] && avs_writedata[F_PVIOL]) begin
               protect_violation_flag_q[i] <= 1'b0;
            end
         end
      end
   end

   // Access sequencer for the processor port and the external bus.
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         st_q <= ST_IDLE;
         addr_q <= 32'h0000_0000;
         fetch_q <= 1'b0;
         write_q <= 1'b0;
         size_q <= 2'h0;
         wdata_q <= 32'h0000_0000;
         cnt_q <= 6'h00;
         burst_q <= 1'b0;
         wp_hit_q <= 1'b0;
         wp_bank_q <= 2'h0;
         last_valid_q <= 1'b0;
         last_write_q <= 1'b0;
         last_bank_q <= 2'h0;
         last_addr_q <= 32'h0000_0000;
         ack_q <= 1'b0;
         dab_q <= 1'b0;
         pab_q <= 1'b0;
         crdata_q <= 32'h0000_0000;
         raddr_q <= 32'h0000_0000;
         rgn_q <= RGN_NONE;
         eaddr_q <= 24'h00_0000;
         cs_n_q <= 4'hf;
         lanes_n_q <= 4'hf;
         oe_n_q <= 1'b1;
         we_n_q <= 1'b1;
         doe_q <= 1'b0;
         dout_q <= 32'h0000_0000;
      end else begin
         ack_q <= 1'b0;
         wp_hit_q <= 1'b0;
         case (st_q)
            ST_IDLE: begin
               if (cpu_req && !ack_q) begin
                  addr_q <= cpu_addr;
                  fetch_q <= cpu_fetch;
                  write_q <= cpu_write && !cpu_fetch;
                  size_q <= cpu_size;
                  wdata_q <= cpu_wdata;
                  dab_q <= 1'b0;
                  pab_q <= 1'b0;
                  st_q <= ST_DECODE;
               end
            end
            ST_DECODE: begin
               rgn_q <= dec_region;
               raddr_q <= dec_addr;
               dab_q <= dec_abort && !fetch_q;
               pab_q <= dec_abort && fetch_q;
               burst_q <= is_burst;
               if (dec_abort || dec_region != RGN_EXT) begin
                  st_q <= ST_DONE;
               end else if (write_q && cfg[F_WP]) begin
                  wp_hit_q <= 1'b1;
                  wp_bank_q <= bank;
                  st_q <= ST_DONE;
               end else if (need_turn) begin
                  cnt_q <= 6'(cfg[F_IDCY +: 4]);
                  st_q <= ST_TURN;
               end else begin
                  st_q <= ST_LAUNCH;
               end
            end
            ST_TURN: begin
               if (cnt_q == 6'h00) begin
                  st_q <= ST_LAUNCH;
               end else begin
                  cnt_q <= cnt_q - 6'h01;
               end
            end
            ST_LAUNCH: begin
               eaddr_q <= raddr_q[BANK_LSB-1:0] >> shift;
               st_q <= ST_STROBE;
               if (write_q) begin
                  dout_q <= wdata_q;
                  doe_q <= 1'b1;
                  cnt_q <= 6'(cfg[F_WST2 +: 5]);
               end else begin
                  cs_n_q <= ~(4'h1 << bank);
                  oe_n_q <= 1'b0;
                  lanes_n_q <= cfg[F_RBLE] ? ~lane_mask : 4'hf;
                  cnt_q <= burst_q ? 6'(cfg[F_WST2 +: 5]) : 6'(cfg[F_WST1 +: 5]) + 6'h02;
               end
            end
            ST_STROBE: begin
               if (write_q) begin
                  cs_n_q <= ~(4'h1 << bank);
                  we_n_q <= 1'b0;
                  lanes_n_q <= ~lane_mask;
               end
               if (cnt_q == 6'h00) begin
                  if (write_q) begin
                     st_q <= ST_HOLD;
                  end else begin
                     crdata_q <= ext_data_i;
                     cs_n_q <= 4'hf;
                     oe_n_q <= 1'b1;
                     lanes_n_q <= 4'hf;
                     st_q <= ST_DONE;
                  end
                  last_valid_q <= 1'b1;
                  last_write_q <= write_q;
                  last_bank_q <= bank;
                  last_addr_q <= raddr_q;
               end else begin
                  cnt_q <= cnt_q - 6'h01;
               end
            end
            ST_HOLD: begin
               we_n_q <= 1'b1;
               lanes_n_q <= 4'hf;
               st_q <= ST_DONE;
            end
            ST_DONE: begin
               // Chip select and data drive end a cycle after write enable, so data is held.
               cs_n_q <= 4'hf;
               doe_q <= 1'b0;
               ack_q <= 1'b1;
               st_q <= ST_IDLE;
            end
            default: begin
               st_q <= ST_IDLE;
            end
         endcase
      end
   end

   assign avs_waitrequest = wait_q;
   assign avs_readdata = rdata_q;
   assign cpu_ack = ack_q;
   assign cpu_rdata = crdata_q;
   assign rsp_region = rgn_q;
   assign rsp_addr = raddr_q;
   assign data_abort = dab_q;
   assign prefetch_abort = pab_q;
   assign ext_addr = eaddr_q;
   assign ext_cs_n = cs_n_q;
   assign ext_oe_n = oe_n_q;
   assign ext_we_n = we_n_q;
   assign lane_selects_n = lanes_n_q;
   assign ext_data_o = dout_q;
   assign ext_data_oe = doe_q;

   // A write in the same cycle as reset release is lost, so check the next cycle only.
   reset_map_a: assert property (@(posedge sys_clk) srst |=> mode_q == MODE_BOOT)
      else $error("mapping mode not boot after reset");

   ram_window_a: assert property (@(posedge sys_clk) disable iff (srst)
      st_q == ST_DECODE && (addr_q & ~WIN_MASK) == 32'h0 && mode_q == MODE_RAM
      |=> rsp_addr == (SRAM_BASE | (addr_q & WIN_MASK)) && rsp_region == RGN_SRAM)
      else $error("low window not served from sram");

   low_reserved_a: assert property (@(posedge sys_clk) disable iff (srst)
      st_q == ST_DECODE && addr_q > WIN_MASK && addr_q <= RSV0_LAST && !fetch_q
      |=> data_abort ##1 cpu_ack && data_abort)
      else $error("reserved low range did not abort");

   fetch_periph_a: assert property (@(posedge sys_clk) disable iff (srst)
      st_q == ST_DECODE && fetch_q && addr_q >= APB_BASE
      |=> prefetch_abort && !data_abort && $stable(ext_cs_n))
      else $error("peripheral fetch missed prefetch abort");

   cs_single_a: assert property (@(posedge sys_clk) disable iff (srst)
      ext_cs_n != 4'hf |-> $onehot0(~ext_cs_n) && (st_q == ST_STROBE || st_q == ST_HOLD
      || st_q == ST_DONE))
      else $error("chip selects not one-hot or active outside access");

   wp_block_a: assert property (@(posedge sys_clk) disable iff (srst)
      st_q == ST_DECODE && write_q && !dec_abort && dec_region == RGN_EXT && cfg[F_WP]
      |=> (ext_we_n && ext_cs_n == 4'hf) [*2] ##0 protect_violation_flag_q[wp_bank_q])
      else $error("protected bank was written or flag not set");

   turn_idle_a: assert property (@(posedge sys_clk) disable iff (srst)
      st_q == ST_TURN |-> ext_cs_n == 4'hf && ext_oe_n && ext_we_n)
      else $error("bus active during turnaround");

   bus_answer_a: assert property (@(posedge sys_clk) disable iff (srst)
      (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("bus slave did not answer in one cycle");

endmodule

// ### verif/mrd_ext_mem.sv
// Behavioural external static memory that answers the bank controller.
module mrd_ext_mem (
   input wire logic sys_clk,
   input wire logic srst,
   input wire logic [23:0] ext_addr,
   input wire logic [3:0] ext_cs_n,
   input wire logic ext_oe_n,
   input wire logic ext_we_n,
   input wire logic [3:0] lane_selects_n,
   input wire logic [31:0] ext_data_o,
   input wire logic ext_data_oe,
   output logic [31:0] ext_data_i,
   output logic [3:0] s_cs_n,
   output logic [23:0] s_addr,
   output logic [3:0] s_lanes,
   output logic [31:0] s_wdata,
   output logic [7:0] oe_len,
   output logic [7:0] we_len,
   output logic [7:0] gap,
   output logic [7:0] wr_cnt
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [31:0] last_q;
   logic [7:0] oe_run;
   logic [7:0] we_run;
   logic [7:0] idle_run;
   logic sel;
   assign sel = ~&ext_cs_n;
   // Off the read strobe the bus flips every cycle, so a mistimed sample cannot pass.
   assign ext_data_i = (sel && !ext_oe_n && !ext_data_oe) ? {8'h5a, ext_addr} : ~last_q;
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         last_q <= 32'h0;
         oe_run <= 8'h0;
         we_run <= 8'h0;
         idle_run <= 8'h0;
         wr_cnt <= 8'h0;
      end else begin
         last_q <= ext_data_i;
         oe_run <= ext_oe_n ? 8'h0 : oe_run + 8'h1;
         if (ext_oe_n && oe_run != 8'h0) oe_len <= oe_run;
         we_run <= ext_we_n ? 8'h0 : we_run + 8'h1;
         if (ext_we_n && we_run != 8'h0) begin
            we_len <= we_run;
            wr_cnt <= wr_cnt + 8'h1;
         end
         idle_run <= sel ? 8'h0 : idle_run + 8'h1;
         if (sel && idle_run != 8'h0) gap <= idle_run;
         if (sel) begin
            s_cs_n <= ext_cs_n;
            s_addr <= ext_addr;
         end
         if (!ext_we_n) begin
            s_lanes <= lane_selects_n;
            s_wdata <= ext_data_o;
         end
      end
   end
endmodule

// ### verif/testbench.sv
// Self-checking bench for the remap, abort and external bank logic.
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import mrd_pkg::*;
   logic sys_clk = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, cpu_req = 1'b0;
   logic cpu_fetch = 1'b0, cpu_write = 1'b0, boot_strap_pin = 1'b1;
   logic [4:0] avs_address = 5'h00;
   logic [31:0] avs_writedata = 32'h0, cpu_addr = 32'h0, cpu_wdata = 32'h0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [1:0] cpu_size = 2'h2, boot_select_pins = 2'h2;
   logic [31:0] avs_readdata, cpu_rdata, rsp_addr, ext_data_o, ext_data_i, rd, s_wdata;
   logic avs_waitrequest, cpu_ack, data_abort, prefetch_abort, ext_oe_n, ext_we_n, ext_data_oe;
   logic [23:0] ext_addr, s_addr;
   logic [3:0] ext_cs_n, lane_selects_n, s_cs_n, s_lanes;
   logic [7:0] oe_len, we_len, gap, wr_cnt, wr_old;
   mrd_region_t rsp_region;
   int num_errors = 0, samples_checked = 0;
   mrd_decoder u_mrd_decoder (.sys_clk, .srst, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .cpu_req, .cpu_addr,
      .cpu_fetch, .cpu_write, .cpu_size, .cpu_wdata, .cpu_ack, .cpu_rdata, .rsp_region,
      .rsp_addr, .data_abort, .prefetch_abort, .boot_strap_pin, .boot_select_pins, .ext_addr,
      .ext_cs_n, .ext_oe_n, .ext_we_n, .lane_selects_n, .ext_data_o, .ext_data_oe, .ext_data_i);
   mrd_ext_mem u_mrd_ext_mem (.sys_clk, .srst, .ext_addr, .ext_cs_n, .ext_oe_n, .ext_we_n,
      .lane_selects_n, .ext_data_o, .ext_data_oe, .ext_data_i, .s_cs_n, .s_addr, .s_lanes,
      .s_wdata, .oe_len, .we_len, .gap, .wr_cnt);
   initial begin
      forever #50 sys_clk = ~sys_clk;
   end
   task finish_test;
      if (num_errors == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task av(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
      int n;
      n = 0;
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= w;
      avs_read <= !w;
      do begin
         @(posedge sys_clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      cmp("avs_waitrequest", 32'h0, 32'(avs_waitrequest));
   endtask
   task rdc(input logic [4:0] a, input logic [31:0] exp, input string nm);
      av(1'b0, a, 32'h0, 4'hf);
      cmp(nm, exp, rd);
   endtask
   // The request stands until the edge that samples the acknowledge.
   task cpu(input logic [31:0] a, input logic f, input logic w, input logic [1:0] sz,
            input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk);
      cpu_addr <= a;
      cpu_fetch <= f;
      cpu_write <= w;
      cpu_size <= sz;
      cpu_wdata <= d;
      cpu_req <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (cpu_ack !== 1'b1 && n < 300);
      cpu_req <= 1'b0;
      cmp("cpu_ack", 32'h1, 32'(cpu_ack));
   endtask
   task dec(input logic [31:0] a, input logic f, input mrd_region_t r, input logic [31:0] na,
            input logic [1:0] ab);
      cpu(a, f, 1'b0, 2'h2, 32'h0);
      cmp("abort", 32'(ab), {30'h0, prefetch_abort, data_abort});
      if (ab == 2'h0) begin
         cmp("rsp_region", 32'(r), 32'(rsp_region));
         cmp("rsp_addr", na, rsp_addr);
      end
   endtask
   initial begin
      repeat (40000) @(posedge sys_clk);
      num_errors++;
      finish_test;
   end
   initial begin
      repeat (16) @(posedge sys_clk);
      srst <= 1'b0;
      rdc(5'h00, BCFG_RST0 | 32'h2000_0000, "bank_zero_config");
      rdc(5'h04, BCFG_RST1, "bank_one_config");
      rdc(5'h0c, BCFG_RST3, "bank_three_config");
      rdc(5'h14, 32'h6, "strap_status");
      rdc(5'h10, 32'(MODE_BOOT), "map_mode");
      av(1'b1, 5'h18, 32'hffff_ffff, 4'hf);
      rdc(5'h18, 32'h0, "unmapped");
      dec(32'h0000_0004, 1'b0, RGN_BOOT, 32'h7fff_e004, 2'h0);
      dec(32'h0000_003c, 1'b1, RGN_BOOT, 32'h7fff_e03c, 2'h0);
      dec(32'h0000_0040, 1'b0, RGN_NONE, 32'h0, 2'h1);
      dec(32'h3fff_fffc, 1'b1, RGN_NONE, 32'h0, 2'h2);
      dec(32'h4000_3ffc, 1'b0, RGN_SRAM, 32'h4000_3ffc, 2'h0);
      dec(32'h4000_4000, 1'b0, RGN_NONE, 32'h0, 2'h1);
      dec(32'h7fff_dffc, 1'b1, RGN_NONE, 32'h0, 2'h2);
      dec(32'h7fff_e000, 1'b0, RGN_BOOT, 32'h7fff_e000, 2'h0);
      dec(32'h8400_0000, 1'b0, RGN_NONE, 32'h0, 2'h1);
      dec(32'hdfff_fffc, 1'b1, RGN_NONE, 32'h0, 2'h2);
      dec(32'he001_8000, 1'b0, RGN_NONE, 32'h0, 2'h1);
      dec(32'he020_0000, 1'b0, RGN_NONE, 32'h0, 2'h1);
      dec(32'hffe0_4000, 1'b0, RGN_NONE, 32'h0, 2'h1);
      dec(32'hffe0_0000, 1'b0, RGN_AHB, 32'hffe0_0000, 2'h0);
      dec(32'he000_d000, 1'b0, RGN_APB, 32'he000_d000, 2'h0);
      dec(32'he000_c000, 1'b1, RGN_NONE, 32'h0, 2'h2);
      dec(32'hffe0_0000, 1'b1, RGN_NONE, 32'h0, 2'h2);
      av(1'b1, 5'h04, 32'h2000_1480, 4'hf);
      av(1'b1, 5'h0c, 32'h0000_0005, 4'hf);
      cpu(32'h8100_0010, 1'b0, 1'b0, 2'h2, 32'h0);
      cmp("cpu_rdata", 32'h5a00_0004, cpu_rdata);
      cmp("chip_select", 32'hd, 32'(s_cs_n));
      cmp("read_len", 32'd7, 32'(oe_len));
      cpu(32'h8100_0020, 1'b0, 1'b1, 2'h2, 32'h1234_5678);
      cmp("ext_data_o", 32'h1234_5678, s_wdata);
      cmp("lane_selects_n", 32'h0, 32'(s_lanes));
      cmp("write_len", 32'd3, 32'(we_len));
      cmp("ext_addr", 32'h8, 32'(s_addr));
      cpu(32'h8300_0021, 1'b0, 1'b0, SZ_BYTE, 32'h0);
      cmp("ext_addr", 32'h21, 32'(s_addr));
      cmp("chip_select", 32'h7, 32'(s_cs_n));
      cmp("turnaround", 32'h1, 32'(gap >= 8'd6));
      av(1'b1, 5'h04, 32'h2400_1480, 4'hf);
      wr_old = wr_cnt;
      cpu(32'h8100_0000, 1'b0, 1'b1, 2'h2, 32'h0bad_f00d);
      cmp("write_count", 32'(wr_old), 32'(wr_cnt));
      rdc(5'h04, 32'h2600_1480, "protect_violation_flag");
      av(1'b1, 5'h04, 32'h2600_0000, 4'h8);
      rdc(5'h04, 32'h2400_1480, "protect_violation_flag");
      av(1'b1, 5'h04, 32'h2800_1480, 4'hf);
      cpu(32'h8100_0000, 1'b0, 1'b0, 2'h2, 32'h0);
      cmp("read_len", 32'd7, 32'(oe_len));
      cpu(32'h8100_0004, 1'b0, 1'b0, 2'h2, 32'h0);
      cmp("burst_len", 32'd3, 32'(oe_len));
      cmp("cpu_rdata", 32'h5a00_0001, cpu_rdata);
      av(1'b1, 5'h10, 32'h1, 4'hf);
      rdc(5'h10, 32'(MODE_RAM), "map_mode");
      dec(32'h0000_0008, 1'b0, RGN_SRAM, 32'h4000_0008, 2'h0);
      dec(32'h4000_0008, 1'b0, RGN_SRAM, 32'h4000_0008, 2'h0);
      av(1'b1, 5'h10, 32'h3, 4'hf);
      rdc(5'h10, 32'(MODE_RAM), "map_mode");
      av(1'b1, 5'h10, 32'h2, 4'hf);
      dec(32'h0000_0010, 1'b0, RGN_EXT, 32'h8000_0010, 2'h0);
      dec(32'h7fff_e010, 1'b0, RGN_BOOT, 32'h7fff_e010, 2'h0);
      srst <= 1'b1;
      repeat (16) @(posedge sys_clk);
      srst <= 1'b0;
      rdc(5'h10, 32'(MODE_BOOT), "map_mode");
      dec(32'h0000_0004, 1'b0, RGN_BOOT, 32'h7fff_e004, 2'h0);
      finish_test;
   end
endmodule
